// file: dv/asp_host_checker.sv
// pin and handshake checks for the sram host port
// assumes it is bound onto asp_host, one clk_sys domain
`timescale 1ns/10ps
module asp_host_checker
  import asp_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic              cs_n,
  input wire logic              oe_n,
  input wire logic              we_n,
  input wire logic [DATA_W-1:0] data_bus_o,
  input wire logic              data_bus_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_no_fight: assert property (!oe_n |-> data_bus_oe_n)
    else $error("host drives bus while memory outputs on");
  a_wr_strobe: assert property (!we_n |-> !cs_n && oe_n && !data_bus_oe_n
    ) else $error("write strobe without select or data");
  a_wr_end: assert property ($fell(we_n) |=> we_n && cs_n)
    else $error("write not ended after one cycle");
  a_wr_data: assert property (!we_n |-> $stable(data_bus_o))
    else $error("write data moved during strobe");
  a_addr_steady: assert property (!cs_n |-> $stable(address_bus))
    else $error("address moved while selected");
  a_rd_start: assert property (req_valid && req_ready && !req_write |->
    ##2 !cs_n && !oe_n && we_n) else $error("read pins late");
  a_rd_len: assert property ($fell(oe_n) |-> !oe_n[*5] ##1
    (oe_n && rsp_valid)) else $error("read window length wrong");
  a_wr_start: assert property (req_valid && req_ready && req_write |->
    ##2 !we_n ##1 we_n) else $error("write strobe misplaced");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
endmodule : asp_host_checker

// file: dv/asp_sram_model.sv
// behavioural 2k x 8 asynchronous static ram facing the host port
// assumes host pins wired directly; drives the resolved data bus
`timescale 1ns/10ps
module asp_sram_model
  import asp_pkg::*;
#(
  parameter int ACC_NS = T_ACCESS_NS  // read access delay, ns
)
(
  input  wire logic [ADDR_W-1:0] address_bus,
  input  wire logic              cs_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [DATA_W-1:0] host_d,
  input  wire logic              host_oe_n,
  output logic      [DATA_W-1:0] bus
);
  logic [DATA_W-1:0] mem [DEPTH];  // storage array
  logic [DATA_W-1:0] rd;           // delayed array output
  logic [DATA_W-1:0] last = '0;    // last driven bus level
  // outputs on only when selected, enabled, not writing
  wire drv = !cs_n && !oe_n && we_n;
  // old byte lingers until the new one arrives
  assign #(ACC_NS) rd = mem[address_bus];
  // released bus shows the inverse of its last level
  assign bus = drv ? rd : (!host_oe_n ? host_d : ~last);
  always @(bus) begin
    if (drv || !host_oe_n)
      last = bus;
  end
  // store while select and strobe overlap low
  always @(cs_n, we_n, address_bus, bus) begin
    if (!cs_n && !we_n)
      mem[address_bus] = bus;
  end
endmodule : asp_sram_model

// file: dv/async_sram_2kx8_port_bench.sv
// random and corner traffic through the host port into the model
// assumes asp_pkg, asp_host, checker and model compiled first
`timescale 1ns/10ps
module async_sram_2kx8_port_bench;
  import asp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              req_ready, rsp_valid, cs_n, oe_n, we_n, data_bus_oe_n;
  logic [DATA_W-1:0] rsp_rdata, data_bus_o, data_bus;
  logic [ADDR_W-1:0] address_bus;
  logic [DATA_W-1:0] exp_mem [DEPTH];  // expected contents
  logic [ADDR_W-1:0] used [$];         // addresses written so far
  int                error_cnt = 0;
  int                n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  asp_host i_asp_host (.clk_sys, .rst_n, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .address_bus, .cs_n, .oe_n, .we_n, .data_bus_i(data_bus),
    .data_bus_o, .data_bus_oe_n);
  asp_sram_model i_asp_sram_model (.address_bus, .cs_n, .oe_n, .we_n,
    .host_d(data_bus_o), .host_oe_n(data_bus_oe_n), .bus(data_bus));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // one access; waits for ready, reads are checked against expectation
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    // outputs looked at mid-cycle, inputs moved on the rising edge
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    if (req_ready !== 1'b1)
      error_cnt++;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    if (w) begin
      exp_mem[a] = d;
      used.push_back(a);
    end
    // count edges after the take edge until the answer stands
    while (!w && n < 10) begin
      @(posedge clk_sys);
      n++;
      @(negedge clk_sys);
      if (rsp_valid === 1'b1)
        break;
    end
    if (!w) begin
      chk("read latency", 8'(n), 8'h06);
      chk("read data", rsp_rdata, exp_mem[a]);
    end
  endtask : acc
  initial begin
    void'($urandom(32'hcf24));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("idle pins", 8'({cs_n, oe_n, we_n, data_bus_oe_n}), 8'h0f);
    acc(1'b1, 11'h000, 8'h5a);
    acc(1'b1, 11'h7ff, 8'ha5);
    acc(1'b0, 11'h000, 8'h00);
    acc(1'b0, 11'h7ff, 8'h00);
    acc(1'b1, 11'h7ff, 8'h3c);
    acc(1'b0, 11'h7ff, 8'h00);
    repeat (60) begin
      if (used.size() == 0 || $urandom_range(1))
        acc(1'b1, ADDR_W'($urandom), DATA_W'($urandom));
      else
        acc(1'b0, used[$urandom_range(used.size() - 1)], 8'h00);
    end
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
endmodule : async_sram_2kx8_port_bench
bind asp_host asp_host_checker i_asp_host_checker (.clk_sys, .rst_n,
  .req_valid, .req_write, .req_ready, .rsp_valid, .address_bus, .cs_n,
  .oe_n, .we_n, .data_bus_o, .data_bus_oe_n);

// file: rtl/asp_host.sv
// host sequencer driving an asynchronous 2k x 8 static ram by its pins
// assumes the memory pins are wired directly; bus level resolved outside
// Operation
// - write lasts while cs and we overlap
// - data setup measured from terminating edge
// - address valid by cs falling edge
// - address held 30 ns before write end
// - address may change at write end
// - address stable when write begins
// - write data held 15 ns before end
// - data may drop at write end
`timescale 1ns/10ps
module asp_host
  import asp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // user request side
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  // memory pins
  output logic [ADDR_W-1:0]      address_bus,
  output logic                   cs_n,
  output logic                   oe_n,
  output logic                   we_n,
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  output logic                   data_bus_oe_n
);
  asp_sync_if sync_c ();                 // synchronised read data

  asp_state_t        st_q, st_d;         // sequencer state
  logic [CNT_W-1:0]  cnt_q, cnt_d;       // timing counter
  logic [ADDR_W-1:0] addr_q, addr_d;     // address pins
  logic [DATA_W-1:0] wdat_q, wdat_d;     // write data pins
  logic              drv_n_q, drv_n_d;   // bus enable, low drives
  logic              cs_n_q, cs_n_d;     // chip select pin
  logic              oe_n_q, oe_n_d;     // output enable pin
  logic              we_n_q, we_n_d;     // write strobe pin
  logic              rdy_q, rdy_d;       // accepting requests
  logic              rv_q, rv_d;         // read answer pulse
  logic [DATA_W-1:0] rdat_q, rdat_d;     // read answer data

  // sampling the returning bus through three flops and an accept flop
  asp_in_sync u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_i   (data_bus_i),
    .sync    (sync_c.src)
  );

  // read sequence, by clk_sys edge counted from the take edge:
  //   take   : address onto the pins, bus released, ready drops
  //   +1     : select and output enable fall together, count loaded
  //   +2..+5 : count runs down; the memory answers within the first
  //            cycle and the byte then walks through the three sync
  //            stages and the accept flop
  //   +6     : accepted byte captured, answer pulse, select released
  //   +7     : end state passes, ready again
  // the wait is set by the synchroniser more than by the memory: a
  // faster grade would not shorten it, a slower one would add cycles
  // through the access count only
  // hazard: the first bus sample after select falls may still show
  // the released level; the wait covers it
  // the address stands unchanged from one cycle before select falls
  // until after select rises, so each request is one clean access
  // write sequence, same counting:
  //   take   : address and data onto the pins, ready drops
  //   +1     : host drives the bus, select and strobe fall together
  //   +2     : select and strobe rise together, ending the write
  //   +3     : bus released, ready again
  // the address stands a whole cycle before the strobes fall and the data
  // is driven onto the bus with them, so both setups to the end of the write are met, the address one with a cycle to spare
  // ending on both strobes at once means either rising edge may be
  // taken as the terminating one; nothing needs to hold after it
  // the host never drives the bus while output enable is low, and
  // output enable stays high through a write, so the two drivers
  // never meet on the bus
  // limitation: one access at a time, no overlap of requests; the
  // user side sees ready low for the whole sequence
  // limitation: the memory's own timing is met by whole cycles of
  // the clock; the counts follow the clock figure in the package
  // next-state and pin values
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    drv_n_d = drv_n_q;
    cs_n_d  = cs_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    rdy_d   = rdy_q;
    rv_d    = 1'b0;
    rdat_d  = rdat_q;
    unique case (st_q)
      ASP_IDLE: begin
        // deselected between accesses, memory idles in standby
        cs_n_d = 1'b1;
        if (req_valid && rdy_q) begin
          addr_d = req_addr;
          rdy_d  = 1'b0;
          if (req_write) begin
            wdat_d = req_wdata;
            st_d   = ASP_WSET;
          end else begin
            drv_n_d = 1'b1;
            st_d    = ASP_RSET;
          end
        end
      end
      ASP_RSET: begin
        // address already stable; select and enable outputs together
        cs_n_d = 1'b0;
        oe_n_d = 1'b0;
        we_n_d = 1'b1;
        cnt_d  = RD_LEN;
        st_d   = ASP_RWAIT;
      end
      ASP_RWAIT: begin
        // wait access time plus synchroniser settle
        if (cnt_q == CNT_ZERO) begin
          rdat_d = sync_c.data;
          rv_d   = 1'b1;
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
          st_d   = ASP_END;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ASP_WSET: begin
        // address and data on pins one cycle ahead of the strobes
        drv_n_d = 1'b0;
        oe_n_d  = 1'b1;
        cs_n_d  = 1'b0;
        we_n_d  = 1'b0;
        cnt_d   = WR_LEN;
        st_d    = ASP_WPULS;
      end
      ASP_WPULS: begin
        // hold overlap for address and data setup to the end
        if (cnt_q == CNT_ONE) begin
          we_n_d = 1'b1;
          cs_n_d = 1'b1;
          st_d   = ASP_END;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ASP_END: begin
        // release bus one cycle after write end, no hold needed
        drv_n_d = 1'b1;
        rdy_d   = 1'b1;
        st_d    = ASP_IDLE;
      end
      default: begin
        st_d    = ASP_IDLE;
        drv_n_d = 1'b1;
        cs_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        rdy_d   = 1'b1;
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ASP_IDLE;
      cnt_q   <= CNT_ZERO;
      addr_q  <= '0;
      wdat_q  <= '0;
      drv_n_q <= 1'b1;
      cs_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      rdy_q   <= 1'b1;
      rv_q    <= 1'b0;
      rdat_q  <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      drv_n_q <= drv_n_d;
      cs_n_q  <= cs_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rdat_q  <= rdat_d;
    end
  end

  // outputs straight from flops
  assign address_bus   = addr_q;
  assign data_bus_o    = wdat_q;
  assign data_bus_oe_n = drv_n_q;
  assign cs_n          = cs_n_q;
  assign oe_n          = oe_n_q;
  assign we_n          = we_n_q;
  assign req_ready     = rdy_q;
  assign rsp_valid     = rv_q;
  assign rsp_rdata     = rdat_q;
endmodule : asp_host

// file: rtl/asp_in_sync.sv
// three-stage synchroniser for the data bus returning from the memory
// assumes the pins change freely against clk_sys
`timescale 1ns/10ps
module asp_in_sync
  import asp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [DATA_W-1:0] pin_i,
  asp_sync_if.src                sync
);
  logic [DATA_W-1:0] s1_q, s2_q, s3_q, acc_q;  // stages and accepted value
  logic [DATA_W-1:0] acc_d;

  // accept a new value once stages two and three agree
  always_comb begin
    acc_d = (s2_q == s3_q) ? s3_q : acc_q;
  end

  // registers only; first stage read by second stage alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      acc_q <= '0;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      acc_q <= acc_d;
    end
  end

  assign sync.data = acc_q;
endmodule : asp_in_sync

// file: rtl/asp_pkg.sv
// package for the sram host port: pin widths, timing figures, states
// assumes a 25 MHz system clock driving all host logic
package asp_pkg;
  localparam int ADDR_W = 11;            // address_bus width
  localparam int DATA_W = 8;             // data_bus width
  localparam int DEPTH  = 2048;          // words in the memory
  localparam int CLK_PERIOD_NS = 40;     // clk_sys period
  // speed grade figures, ns (35 ns grade)
  localparam int T_ACCESS_NS   = 35;     // address_access_time
  localparam int T_OH_NS       = 5;      // read data hold after addr change
  localparam int T_AW_NS       = 30;     // addr_setup_to_write_end
  localparam int T_SD_NS       = 15;     // data_setup_to_write_end
  localparam int T_HA_NS       = 0;      // addr_hold_after_write_end
  localparam int T_SA_NS       = 0;      // addr_setup_to_write_start
  localparam int T_HD_NS       = 0;      // data_hold_after_write_end
  // least times round up, at least one cycle
  localparam int RD_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AW_CYC = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (AW_CYC > SD_CYC) ? AW_CYC : SD_CYC;
  localparam int CNT_W  = 4;             // timing counter width
  // read wait adds the three sync stages and the accept flop
  localparam logic [CNT_W-1:0] RD_LEN = CNT_W'(RD_CYC + 3);
  localparam logic [CNT_W-1:0] WR_LEN = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  // host sequencer states
  typedef enum logic [2:0] {
    ASP_IDLE  = 3'b000,
    ASP_RSET  = 3'b001,
    ASP_RWAIT = 3'b010,
    ASP_WSET  = 3'b011,
    ASP_WPULS = 3'b100,
    ASP_END   = 3'b101
  } asp_state_t;
endpackage : asp_pkg

// file: rtl/asp_sync_if.sv
// interface carrying a synchronised data bus sample to the sequencer
// assumes both ends run on clk_sys
`timescale 1ns/10ps
interface asp_sync_if;
  import asp_pkg::*;
  logic [DATA_W-1:0] data;   // stable sample of the data bus
  modport src (output data);
  modport dst (input  data);
endinterface : asp_sync_if
